// file: inc/bdcc_defines.vh
// constants for the backup-domain calendar counter
`ifndef BDCC_DEFINES_VH
`define BDCC_DEFINES_VH

// word offsets (byte address bits 7:0)
`define BDCC_ADR_CTRL      8'h00
`define BDCC_ADR_CTRLLO    8'h04
`define BDCC_ADR_PRL_HI    8'h08
`define BDCC_ADR_PRL_LO    8'h0C
`define BDCC_ADR_DIV_HI    8'h10
`define BDCC_ADR_DIV_LO    8'h14
`define BDCC_ADR_CNT_HI    8'h18
`define BDCC_ADR_CNT_LO    8'h1C
`define BDCC_ADR_ALR_HI    8'h20
`define BDCC_ADR_ALR_LO    8'h24
`define BDCC_ADR_ACCESS    8'h28

// control register fields
`define BDCC_CR_SECIE      0
`define BDCC_CR_ALRIE      1
`define BDCC_CR_OVFIE      2

// control low register fields
`define BDCC_CL_SECOND_TICK_FLAG       0
`define BDCC_CL_ALARM_MATCH_FLAG       1
`define BDCC_CL_OVFF       2
`define BDCC_CL_RSF        3
`define BDCC_CL_CNF        4
`define BDCC_CL_WDONE      5

// access register fields
`define BDCC_AC_POWER_IFACE_CLOCK_ENABLE      0
`define BDCC_AC_BACKUP_IFACE_CLOCK_ENABLE      1
`define BDCC_AC_UNPROT     2
`define BDCC_AC_KSEL_LO    8
`define BDCC_AC_KSEL_HI    9

// kernel clock selections
`define BDCC_KSEL_NONE     2'h0
`define BDCC_KSEL_LOCAL    2'h1
`define BDCC_KSEL_LSE      2'h2
`define BDCC_KSEL_LSI      2'h3

// pending-write mask bits
`define BDCC_PEND_PRL      0
`define BDCC_PEND_CNT      1
`define BDCC_PEND_ALR      2

// last commit count (a commit takes three kernel cycles), and counter steps for it
`define BDCC_CMT_LAST      2'h2
`define BDCC_CMT_ZERO      2'h0
`define BDCC_CMT_ONE       2'h1

// reset values and counter/divider constants
`define BDCC_RST_PRL       20'h00000
`define BDCC_RST_DIV       20'h00000
`define BDCC_RST_CNT       32'h00000000
`define BDCC_RST_ALR       32'h00000000
`define BDCC_CNT_MAX       32'hFFFFFFFF
`define BDCC_DIV_ZERO      20'h00000
`define BDCC_DIV_ONE       20'h00001
`define BDCC_CNT_ONE       32'h00000001
`define BDCC_ZERO16        16'h0000
`define BDCC_ZERO32        32'h00000000

`endif

// file: logic/bdcc_rtc.v
// backup-domain calendar counter: wishbone interface and core
// Operation
// - twenty-bit divider makes tick from kernel clock
// - tick raises second interrupt when enabled
// - loadable counter counts ticks, alarm compared
// - sixteen-bit registers on bus clock
// - system reset spares prescaler, alarm, counter, divider
// - writes other than the access enables blocked until enables and unprotect set
// - core and time survive system reset
// - kernel clock chosen among three sources
// - separate alarm, second, overflow interrupt lines
// - readable copies refresh per kernel edge, resynced
// - synced flag set after first copy update
// - prescaler, counter, alarm writable only in config
// - write-done low during update, gates writes
// - commit on config exit, three kernel cycles
// - second flag set in same cycle as counter update
// - overflow flag set in same cycle as wrap
// - alarm flag set in same cycle as counter reaches alarm plus one
// - bus side keeps running in sleep modes
`timescale 1ns/10ps
`default_nettype none
`include "bdcc_defines.vh"

module bdcc_rtc (
    input  wire        clk,
    input  wire        resetn,
    input  wire        bkp_resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        interconnect_local_clock,
    input  wire        external_low_speed_osc,
    input  wire        internal_low_speed_osc,
    output reg         irq_second,
    output reg         irq_alarm,
    output reg         irq_overflow,
    output reg         alarm_out
);

    // byte-lane merge into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  sel;
        begin
            merge16 = {sel[1] ? wd[15:8] : old[15:8],
                       sel[0] ? wd[7:0]  : old[7:0]};
        end
    endfunction

    // ---------------- core state (backup domain) ----------------
    reg  [19:0] prescaler_load;
    reg  [19:0] divider;
    reg  [31:0] time_counter;
    reg  [31:0] alarm_value;
    reg  [1:0]  kernel_sel;

    // ------ bus-side state (system reset; kclk_q, kclk_qq on backup reset) ------
    reg  [2:0]  control_register;
    reg         second_tick_flag;
    reg         alarm_match_flag;
    reg         rollover_flag;
    reg         regs_synced_flag;
    reg         config_mode_bit;
    reg         write_done_flag;
    reg         power_iface_clock_enable;
    reg         backup_iface_clock_enable;
    reg         backup_write_unprotect;
    reg  [19:0] shadow_prl;
    reg  [31:0] shadow_cnt;
    reg  [31:0] shadow_alr;
    reg  [2:0]  pending;
    reg  [1:0]  commit_cnt;
    reg         commit_pulse;
    reg  [19:0] prl_copy;
    reg  [19:0] div_copy;
    reg  [31:0] cnt_copy;
    reg  [31:0] alr_copy;
    reg         kclk_q;
    reg         kclk_qq;
    reg         kedge_d;

    // ---------------- bus access decode ----------------
    wire        bus_req  = wb_cyc_i & wb_stb_i;
    wire        wr_take  = bus_req & wb_ack_o & wb_we_i;
    wire [1:0]  lanes    = wb_sel_i[1:0];
    wire [15:0] wd       = wb_dat_i[15:0];
    wire        unlocked = power_iface_clock_enable &
                           backup_iface_clock_enable &
                           backup_write_unprotect;
    wire        wr_rtc   = wr_take & unlocked & write_done_flag;
    wire        wr_cfg   = wr_rtc & config_mode_bit;
    wire        wr_access = wr_take & (wb_adr_i == `BDCC_ADR_ACCESS);
    wire        wr_ctrllo = wr_rtc & (wb_adr_i == `BDCC_ADR_CTRLLO);

    // kernel clock source mux and edge detect; sources are
    // synchronous levels, so the registered copy is safe to compare
    reg kclk_mux;
    always @* begin
        case (kernel_sel)
            `BDCC_KSEL_LOCAL: kclk_mux = interconnect_local_clock;
            `BDCC_KSEL_LSE:   kclk_mux = external_low_speed_osc;
            `BDCC_KSEL_LSI:   kclk_mux = internal_low_speed_osc;
            default:          kclk_mux = 1'b0;
        endcase
    end

    // edge detector lives in the backup domain so the core keeps
    // counting through a system reset
    always @(posedge clk or negedge bkp_resetn) begin
        if (!bkp_resetn) begin
            kclk_q  <= 1'b0;
            kclk_qq <= 1'b0;
        end else begin
            kclk_q  <= kclk_mux;
            kclk_qq <= kclk_q;
        end
    end

    wire kedge    = kclk_q & ~kclk_qq;
    wire tick     = kedge & (divider == `BDCC_DIV_ZERO);
    wire ev_sec   = tick;
    wire ev_ovf   = tick & (time_counter == `BDCC_CNT_MAX);
    wire ev_alr   = tick & (time_counter == alarm_value);

    // ---------------- core process ----------------
    // only the backup reset touches these
    always @(posedge clk or negedge bkp_resetn) begin
        if (!bkp_resetn) begin
            prescaler_load <= `BDCC_RST_PRL;
            divider        <= `BDCC_RST_DIV;
            time_counter   <= `BDCC_RST_CNT;
            alarm_value    <= `BDCC_RST_ALR;
            kernel_sel     <= `BDCC_KSEL_NONE;
        end else begin
            if (wr_access & unlocked) begin
                kernel_sel <= wb_dat_i[`BDCC_AC_KSEL_HI:`BDCC_AC_KSEL_LO];
            end
            if (kedge) begin
                if (tick) begin
                    divider      <= prescaler_load;
                    time_counter <= time_counter + `BDCC_CNT_ONE;
                end else begin
                    divider <= divider - `BDCC_DIV_ONE;
                end
            end
            // a commit overrides the same-cycle count step
            if (commit_pulse) begin
                if (pending[`BDCC_PEND_PRL]) begin
                    prescaler_load <= shadow_prl;
                    divider        <= shadow_prl;
                end
                if (pending[`BDCC_PEND_CNT]) begin
                    time_counter <= shadow_cnt;
                end
                if (pending[`BDCC_PEND_ALR]) begin
                    alarm_value <= shadow_alr;
                end
            end
        end
    end

    // ---------------- bus-side process ----------------
    wire cnf_exit = wr_ctrllo & config_mode_bit & ~wd[`BDCC_CL_CNF] &
                    lanes[0];
    wire wd_sel0  = wr_ctrllo & lanes[0];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            control_register          <= 3'h0;
            second_tick_flag          <= 1'b0;
            alarm_match_flag          <= 1'b0;
            rollover_flag             <= 1'b0;
            regs_synced_flag          <= 1'b0;
            config_mode_bit           <= 1'b0;
            write_done_flag           <= 1'b1;
            power_iface_clock_enable  <= 1'b0;
            backup_iface_clock_enable <= 1'b0;
            backup_write_unprotect    <= 1'b0;
            shadow_prl                <= `BDCC_RST_PRL;
            shadow_cnt                <= `BDCC_RST_CNT;
            shadow_alr                <= `BDCC_RST_ALR;
            pending                   <= 3'h0;
            commit_cnt                <= `BDCC_CMT_ZERO;
            commit_pulse              <= 1'b0;
            prl_copy                  <= `BDCC_RST_PRL;
            div_copy                  <= `BDCC_RST_DIV;
            cnt_copy                  <= `BDCC_RST_CNT;
            alr_copy                  <= `BDCC_RST_ALR;
            kedge_d                   <= 1'b0;
        end else begin
            commit_pulse <= 1'b0;
            kedge_d      <= kedge;

            // refresh copies one cycle after the kernel edge
            if (kedge_d) begin
                prl_copy <= prescaler_load;
                div_copy <= divider;
                cnt_copy <= time_counter;
                alr_copy <= alarm_value;
            end

            // access enables are always writable
            if (wr_access & lanes[0]) begin
                power_iface_clock_enable  <= wd[`BDCC_AC_POWER_IFACE_CLOCK_ENABLE];
                backup_iface_clock_enable <= wd[`BDCC_AC_BACKUP_IFACE_CLOCK_ENABLE];
                backup_write_unprotect    <= wd[`BDCC_AC_UNPROT];
            end

            if (wr_rtc & lanes[0] & (wb_adr_i == `BDCC_ADR_CTRL)) begin
                control_register <= wd[2:0];
            end

            // flags clear on written zero; a set in the same cycle wins
            second_tick_flag <= ev_sec | (second_tick_flag &
                ~(wd_sel0 & ~wd[`BDCC_CL_SECOND_TICK_FLAG]));
            alarm_match_flag <= ev_alr | (alarm_match_flag &
                ~(wd_sel0 & ~wd[`BDCC_CL_ALARM_MATCH_FLAG]));
            rollover_flag    <= ev_ovf | (rollover_flag &
                ~(wd_sel0 & ~wd[`BDCC_CL_OVFF]));
            regs_synced_flag <= kedge_d | (regs_synced_flag &
                ~(wd_sel0 & ~wd[`BDCC_CL_RSF]));
            if (wd_sel0) begin
                config_mode_bit <= wd[`BDCC_CL_CNF];
            end

            // shadow writes, held until config mode is left
            if (wr_cfg) begin
                case (wb_adr_i)
                    `BDCC_ADR_PRL_HI: begin
                        if (lanes[0]) shadow_prl[19:16] <= wd[3:0];
                        pending[`BDCC_PEND_PRL] <= 1'b1;
                    end
                    `BDCC_ADR_PRL_LO: begin
                        shadow_prl[15:0] <=
                            merge16(shadow_prl[15:0], wd, lanes);
                        pending[`BDCC_PEND_PRL] <= 1'b1;
                    end
                    `BDCC_ADR_CNT_HI: begin
                        shadow_cnt[31:16] <=
                            merge16(shadow_cnt[31:16], wd, lanes);
                        pending[`BDCC_PEND_CNT] <= 1'b1;
                    end
                    `BDCC_ADR_CNT_LO: begin
                        shadow_cnt[15:0] <=
                            merge16(shadow_cnt[15:0], wd, lanes);
                        pending[`BDCC_PEND_CNT] <= 1'b1;
                    end
                    `BDCC_ADR_ALR_HI: begin
                        shadow_alr[31:16] <=
                            merge16(shadow_alr[31:16], wd, lanes);
                        pending[`BDCC_PEND_ALR] <= 1'b1;
                    end
                    `BDCC_ADR_ALR_LO: begin
                        shadow_alr[15:0] <=
                            merge16(shadow_alr[15:0], wd, lanes);
                        pending[`BDCC_PEND_ALR] <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end

            // commit: write-done low for three kernel edges
            if (cnf_exit & (pending != 3'h0)) begin
                write_done_flag <= 1'b0;
                commit_cnt      <= `BDCC_CMT_ZERO;
            end else if (!write_done_flag && kedge) begin
                if (commit_cnt == `BDCC_CMT_LAST) begin
                    commit_pulse    <= 1'b1;
                    write_done_flag <= 1'b1;
                end else begin
                    commit_cnt <= commit_cnt + `BDCC_CMT_ONE;
                end
            end
            if (commit_pulse) begin
                pending <= 3'h0;
            end
        end
    end

    // ---------------- read mux ----------------
    reg [15:0] next_rd;
    always @* begin
        next_rd = `BDCC_ZERO16;
        case (wb_adr_i)
            `BDCC_ADR_CTRL:   next_rd = {13'h0000, control_register};
            `BDCC_ADR_CTRLLO: next_rd = {10'h000, write_done_flag,
                                config_mode_bit, regs_synced_flag,
                                rollover_flag, alarm_match_flag,
                                second_tick_flag};
            `BDCC_ADR_PRL_HI: next_rd = {12'h000, prl_copy[19:16]};
            `BDCC_ADR_PRL_LO: next_rd = prl_copy[15:0];
            `BDCC_ADR_DIV_HI: next_rd = {12'h000, div_copy[19:16]};
            `BDCC_ADR_DIV_LO: next_rd = div_copy[15:0];
            `BDCC_ADR_CNT_HI: next_rd = cnt_copy[31:16];
            `BDCC_ADR_CNT_LO: next_rd = cnt_copy[15:0];
            `BDCC_ADR_ALR_HI: next_rd = alr_copy[31:16];
            `BDCC_ADR_ALR_LO: next_rd = alr_copy[15:0];
            `BDCC_ADR_ACCESS: next_rd = {6'h00, kernel_sel, 5'h00,
                                backup_write_unprotect,
                                backup_iface_clock_enable,
                                power_iface_clock_enable};
            default:          next_rd = `BDCC_ZERO16;
        endcase
    end

    // one-wait-state slave; bus side has no sleep gating
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= `BDCC_ZERO32;
            irq_second   <= 1'b0;
            irq_alarm    <= 1'b0;
            irq_overflow <= 1'b0;
            alarm_out    <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= {16'h0000, next_rd};
            end else begin
                wb_dat_o <= `BDCC_ZERO32;
            end
            irq_second   <= second_tick_flag &
                            control_register[`BDCC_CR_SECIE];
            irq_alarm    <= alarm_match_flag &
                            control_register[`BDCC_CR_ALRIE];
            irq_overflow <= rollover_flag &
                            control_register[`BDCC_CR_OVFIE];
            alarm_out    <= ev_alr;
        end
    end

endmodule // bdcc_rtc

`default_nettype wire

// file: tb/bdcc_rtc_props.sv
// assertion checker for the calendar counter bus and event outputs
`timescale 1ns/10ps
`default_nettype none
module bdcc_rtc_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        interconnect_local_clock,
    input wire logic        external_low_speed_osc,
    input wire logic        internal_low_speed_osc,
    input wire logic        irq_second,
    input wire logic        alarm_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [2:0]  osc_q;
    wire  [2:0]  osc_now = {interconnect_local_clock,
                            external_low_speed_osc, internal_low_speed_osc};
    // rising level on any source; a source rise reaches irq three edges on
    wire         osc_rise = |(osc_now & ~osc_q);
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            osc_q <= 3'h0;
        else
            osc_q <= osc_now;
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_latency: assert property (s_req |=> s_ack)
        else $error("ack missing one cycle after request");
    a_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_idle_no_ack: assert property (!(wb_cyc_i && wb_stb_i) |=>
        !wb_ack_o) else $error("ack after idle cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |->
        wb_dat_o == 32'h00000000) else $error("read data outside ack");
    a_dat_upper_zero: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_alarm_gap: assert property (alarm_out |=> !alarm_out [*8])
        else $error("alarm pulse repeated");
    // an enable write shows two edges on, a select switch four edges on
    a_sec_cause: assert property ($rose(irq_second) |->
        $past(osc_rise, 3) || $past(wb_ack_o, 2) || $past(wb_ack_o, 4))
        else $error("second irq with no cause");
endmodule // bdcc_rtc_chk
bind bdcc_rtc bdcc_rtc_chk u_bdcc_rtc_chk (
    .clk                      (clk),
    .resetn                   (resetn),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_dat_o                 (wb_dat_o),
    .wb_ack_o                 (wb_ack_o),
    .interconnect_local_clock (interconnect_local_clock),
    .external_low_speed_osc   (external_low_speed_osc),
    .internal_low_speed_osc   (internal_low_speed_osc),
    .irq_second               (irq_second),
    .alarm_out                (alarm_out)
);
`default_nettype wire

// file: tb/bdcc_osc_model.sv
// free-running low-speed clock sources, levels synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module bdcc_osc_model (
    input  wire  clk,
    input  wire  resetn,
    output logic src_local,
    output logic src_lse,
    output logic src_lsi
);
    logic [3:0] cnt;
    // three distinct rates so a wrong source select shows in tick speed
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt       <= 4'h0;
            src_local <= 1'b0;
            src_lse   <= 1'b0;
            src_lsi   <= 1'b0;
        end else begin
            cnt       <= cnt + 4'h1;
            src_local <= cnt[1];
            src_lse   <= cnt[2];
            src_lsi   <= cnt[3];
        end
    end
endmodule // bdcc_osc_model
`default_nettype wire

// file: tb/test_bdcc_rtc.sv
// self-checking bench for the calendar counter
`timescale 1ns/10ps
`default_nettype none
`include "bdcc_defines.vh"
module test_bdcc_rtc;
    logic        clk, resetn, bkp_resetn, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, irq_second, irq_alarm, irq_overflow, alarm_out;
    wire         src_local, src_lse, src_lsi;
    int          err_total, comparisons, cycles, n, s;
    logic [15:0] q, a, prl, k;
    bdcc_rtc u_bdcc_rtc (.clk(clk), .resetn(resetn), .bkp_resetn(bkp_resetn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .interconnect_local_clock(src_local), .external_low_speed_osc(src_lse),
        .internal_low_speed_osc(src_lsi), .irq_second(irq_second),
        .irq_alarm(irq_alarm), .irq_overflow(irq_overflow),
        .alarm_out(alarm_out));
    bdcc_osc_model u_bdcc_osc_model (.clk(clk), .resetn(bkp_resetn),
        .src_local(src_local), .src_lse(src_lse), .src_lsi(src_lsi));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude();
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] exp_cl(input logic sf, af, of, rf, wd);
        return {10'h000, wd, 1'b0, rf, of, af, sf};
    endfunction
    // request holds until ack is sampled high at a rising edge; data is
    // taken and the request released at that same edge
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [15:0] wd);
        int t;
        t = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {16'h0000, wd};
        do begin
            @(posedge clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        q = wb_dat_o[15:0];
        if (wb_ack_o !== 1'b1)
            chk("ack", 16'h0001, 16'h0000);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] adr,
                       input logic [15:0] e);
        xfer(1'b0, adr, 16'h0000);
        chk(nm, e, q);
    endtask
    task automatic poll(input int b);
        int t;
        t = 0;
        q = 16'h0000;
        while (q[b] !== 1'b1 && t < 100) begin
            xfer(1'b0, `BDCC_ADR_CTRLLO, 16'h0000);
            t++;
        end
        chk("poll", 16'h0001, {15'h0000, q[b]});
    endtask
    task automatic resync();
        xfer(1'b1, `BDCC_ADR_CTRLLO, 16'h0000);
        poll(`BDCC_CL_RSF);
    endtask
    initial begin
        {resetn, bkp_resetn, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
        wb_sel_i = 4'hF;
        {err_total, comparisons, cycles} = 0;
        void'($urandom(32'hD7D3E7ED));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        bkp_resetn <= 1'b1;
        rdc("access", `BDCC_ADR_ACCESS, 16'h0000);
        rdc("ctrllo", `BDCC_ADR_CTRLLO, exp_cl(0, 0, 0, 0, 1));
        xfer(1'b1, `BDCC_ADR_CTRL, 16'h0007);
        rdc("ctrl locked", `BDCC_ADR_CTRL, 16'h0000);
        xfer(1'b1, `BDCC_ADR_ACCESS, 16'h0007);
        xfer(1'b1, `BDCC_ADR_ACCESS, 16'h0107);
        rdc("access", `BDCC_ADR_ACCESS, 16'h0107);
        xfer(1'b1, `BDCC_ADR_ALR_LO, 16'h1234);
        resync();
        rdc("alarm no cfg", `BDCC_ADR_ALR_LO, 16'h0000);
        prl = 16'h0001 + 16'($urandom % 3);
        // enough ticks before the alarm that the bench is waiting for it
        k = 16'h0010 + 16'($urandom % 4);
        poll(`BDCC_CL_SECOND_TICK_FLAG);
        poll(`BDCC_CL_WDONE);
        xfer(1'b1, `BDCC_ADR_CTRLLO, 16'h0010);
        xfer(1'b1, `BDCC_ADR_PRL_HI, 16'h0000);
        xfer(1'b1, `BDCC_ADR_PRL_LO, prl);
        xfer(1'b1, `BDCC_ADR_CNT_HI, 16'hFFFF);
        xfer(1'b1, `BDCC_ADR_CNT_LO, 16'hFFFF - k);
        xfer(1'b1, `BDCC_ADR_ALR_HI, 16'hFFFF);
        xfer(1'b1, `BDCC_ADR_ALR_LO, 16'hFFFE);
        xfer(1'b1, `BDCC_ADR_CTRLLO, 16'h0000);
        xfer(1'b0, `BDCC_ADR_CTRLLO, 16'h0000);
        chk("wdone busy", 16'h0000, {15'h0000, q[5]});
        poll(`BDCC_CL_WDONE);
        xfer(1'b1, `BDCC_ADR_CTRL, 16'h0007);
        resync();
        rdc("prl", `BDCC_ADR_PRL_LO, prl);
        rdc("alarm", `BDCC_ADR_ALR_LO, 16'hFFFE);
        for (n = 0; n < 3000 && alarm_out !== 1'b1; n++)
            @(posedge clk);
        chk("alarm out", 16'h0001, {15'h0000, alarm_out});
        repeat (2) @(posedge clk);
        chk("irq", 16'h0006, {13'h0, irq_alarm, irq_second, irq_overflow});
        for (n = 0; n < 3000 && irq_overflow !== 1'b1; n++)
            @(posedge clk);
        chk("irq ovf", 16'h0001, {15'h0000, irq_overflow});
        rdc("flags", `BDCC_ADR_CTRLLO, exp_cl(1, 1, 1, 1, 1));
        rdc("cnt hi", `BDCC_ADR_CNT_HI, 16'h0000);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdc("ctrl rst", `BDCC_ADR_CTRL, 16'h0000);
        poll(`BDCC_CL_RSF);
        rdc("prl kept", `BDCC_ADR_PRL_LO, prl);
        rdc("cnt kept", `BDCC_ADR_CNT_HI, 16'h0000);
        xfer(1'b1, `BDCC_ADR_ACCESS, 16'h0007);
        for (s = 3; s >= 0; s--) begin
            xfer(1'b1, `BDCC_ADR_ACCESS, {6'h00, 2'(s), 8'h07});
            repeat (40) @(posedge clk);
            xfer(1'b0, `BDCC_ADR_CNT_LO, 16'h0000);
            a = q;
            repeat (40 * (prl + 1)) @(posedge clk);
            xfer(1'b0, `BDCC_ADR_CNT_LO, 16'h0000);
            a = q - a;
            if (s == 1)
                chk("rate", 16'h0001, {15'h0, a >= 9 && a <= 11});
            else
                chk("runs", {15'h0, s != 0}, {15'h0, a != 0});
        end
        for (n = 0; n < 4; n++) begin
            wb_sel_i <= 4'($urandom);
            a = 16'h002C + 16'(4 * ($urandom % 20));
            xfer(1'b1, a[7:0], 16'($urandom));
            rdc("unmapped", a[7:0], 16'h0000);
        end
        conclude();
    end
endmodule // test_bdcc_rtc
`default_nettype wire
